// [rtl/dac_defs.svh]
/*
  Constants for the digitizer acquisition control block: register offsets,
  field positions, reset values and limits.
  Assumes inclusion by bare name from the design module and the testbench.
*/
`ifndef DAC_DEFS_SVH
`define DAC_DEFS_SVH

// ---------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ---------------------------------------------------------------
`define DAC_REG_MODE      4'h0
`define DAC_REG_CLOCK     4'h1
`define DAC_REG_SYNTH     4'h2
`define DAC_REG_CHAN      4'h3
`define DAC_REG_OFFSET1   4'h4
`define DAC_REG_OFFSET2   4'h5
`define DAC_REG_TRIGGER   4'h6
`define DAC_REG_MEMSIZE   4'h7
`define DAC_REG_STATUS    4'h8
`define DAC_REG_MASK      4'h9
`define DAC_REG_COUNT     4'ha

// ---------------------------------------------------------------
// Limits and reset values
// ---------------------------------------------------------------
`define DAC_EXT_DIV_MIN   5'h01
`define DAC_EXT_DIV_MAX   5'h14
`define DAC_DISCARD_MAX   3'h5
`define DAC_SYNTH_MIN_MHZ 9'h014
`define DAC_SYNTH_MAX_MHZ 9'h190
`define DAC_BAND_LO_MHZ   9'h115
`define DAC_BAND_HI_MHZ   9'h134
`define DAC_SYNTH_RST_MHZ 9'h190
`define DAC_GAIN_MAX      3'h5
`define DAC_MEM_STEP      3'h3
`define DAC_MEM_RST       32'h00000008
`define DAC_HOST_NUM      4'h7
`define DAC_HOST_DEN      4'h8

// ---------------------------------------------------------------
// Status bit positions
// ---------------------------------------------------------------
`define DAC_ST_FULL       0
`define DAC_ST_TRIG       1
`define DAC_ST_STAMP      2
`define DAC_ST_XFER       3

`endif

// [rtl/dac_pkg.sv]
/*
  Types for the digitizer acquisition control block.
  Assumes dac_defs.svh is available on the include path.
*/
`default_nettype none
package dac_pkg;
  typedef enum logic [4:0] {
    ST_STANDBY = 5'h01,
    ST_CAPTURE = 5'h02,
    ST_XFER    = 5'h04,
    ST_STREAM  = 5'h08,
    ST_PSTREAM = 5'h10
  } dac_state_e;

  typedef enum logic [1:0] {
    GPIO_LOW  = 2'h0,
    GPIO_HIGH = 2'h1,
    GPIO_TRIG = 2'h2,
    GPIO_CLK2 = 2'h3
  } dac_gpio_e;
endpackage : dac_pkg
`default_nettype wire

// [rtl/dac_acq_ctrl.sv]
/*
  Acquisition control: clocking selection, sample discard, channel packing,
  trigger detection, operating-mode sequencer and register port.
  Assumes samples arrive synchronous to clock_i with sample_valid_i, the RAM
  and host sides take words on their valid/ready handshakes.
*/
// Summary of operation
// - External clock divided by software ratio 1 to 20.
// - Samples discarded with ratio 1, 2, 4, 8, 16 or 32.
// - Synthesizer 20 to 400 MHz, never inside 277 to 308 MHz.
// - Synthesizer reference chosen between internal and external 10 MHz.
// - Clock connector is either converter clock or synthesizer reference.
// - Each channel has a 12-bit software offset code.
// - Dual channel or single channel 1 or 2 capture.
// - Digital connector outputs high, trigger, clock/2; low selection releases it as input requesting timestamp.
// - Five modes: standby, capture, transfer, stream, processed stream.
// - Transfer to host only after a completed capture.
// - Streaming uses RAM as FIFO, interleaving write and read packets.
// - Host delivery limited to 1.4 of 1.6 GB/s.
// - Processed stream sends samples to processor, only its output to host.
// - External trigger on selectable rising or falling edge.
// - Level trigger on threshold crossing of selected channel, selectable polarity.
// - Each channel has one of six gain settings.
// - Capture ends at programmed count and sets full flag.
// - Memory size from 8 bytes upward in 8-byte steps.
`default_nettype none
`include "dac_defs.svh"
module dac_acq_ctrl #(
  parameter int SW = 14
) (
  // Clock and reset
  input  wire logic          clock_i,
  input  wire logic          reset_i,
  // Register port
  input  wire logic [3:0]    reg_addr_i,
  input  wire logic [31:0]   reg_wdata_i,
  input  wire logic          reg_wr_i,
  input  wire logic          reg_rd_i,
  output logic      [31:0]   reg_rdata_o,
  output logic               irq_o,
  // Converter side
  input  wire logic          sample_valid_i,
  input  wire logic [SW-1:0] sample_ch1_i,
  input  wire logic [SW-1:0] sample_ch2_i,
  input  wire logic          ext_trig_i,
  input  wire logic          gpio_i,
  output logic               gpio_o,
  output logic               gpio_oe_o,
  output logic               stamp_req_o,
  output logic               ext_clk_sel_o,
  output logic               ext_ref_sel_o,
  output logic      [4:0]    ext_div_o,
  output logic      [8:0]    synth_mhz_o,
  output logic      [11:0]   offset1_o,
  output logic      [11:0]   offset2_o,
  output logic      [2:0]    gain1_o,
  output logic      [2:0]    gain2_o,
  // RAM write side
  output logic      [31:0]   ram_wdata_o,
  output logic               ram_wvalid_o,
  input  wire logic          ram_wready_i,
  // RAM read and host side
  input  wire logic          ram_rvalid_i,
  output logic               ram_rready_o,
  input  wire logic [31:0]   ram_rdata_i,
  output logic      [31:0]   host_data_o,
  output logic               host_valid_o,
  input  wire logic          host_ready_i,
  // Processing device side
  output logic      [31:0]   proc_data_o,
  output logic               proc_valid_o,
  input  wire logic          proc_ovalid_i,
  input  wire logic [31:0]   proc_odata_i
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    dac_pkg::dac_state_e state;
    logic                ext_clk;
    logic                ext_ref;
    logic [4:0]          ext_div;
    logic [2:0]          discard;
    logic [8:0]          synth;
    logic [1:0]          chan;
    logic [11:0]         off1;
    logic [11:0]         off2;
    logic [2:0]          gain1;
    logic [2:0]          gain2;
    logic [1:0]          gpio_sel;
    logic                gpio_in;
    logic                trig_en;
    logic                trig_fall;
    logic                lvl_en;
    logic                lvl_fall;
    logic                lvl_ch2;
    logic [SW-1:0]       thresh;
    logic [31:0]         memsize;
    logic [3:0]          status;
    logic [3:0]          mask;
    logic [31:0]         count;
    logic                captured;
    logic                armed;
    logic [4:0]          disc_cnt;
    logic                prev_trig;
    logic                prev_gpio;
    logic                prev_above;
    logic                half;
    logic [15:0]         hold;
    logic                hold_v;
    logic [31:0]         wdata;
    logic                wvalid;
    logic [31:0]         hdata;
    logic                hvalid;
    logic [3:0]          credit;
    logic                clk2;
    logic                trig_pulse;
    logic                stamp;
    logic [31:0]         rdata;
  } dac_regs_s;

  dac_regs_s r_reg;
  dac_regs_s r_next;

  function automatic logic [8:0] synth_clip(input logic [8:0] f);
    logic [8:0] v;
    v = f;
    if (v < `DAC_SYNTH_MIN_MHZ) v = `DAC_SYNTH_MIN_MHZ;
    if (v > `DAC_SYNTH_MAX_MHZ) v = `DAC_SYNTH_MAX_MHZ;
    if (v >= `DAC_BAND_LO_MHZ && v <= `DAC_BAND_HI_MHZ) v = `DAC_BAND_LO_MHZ - 9'h001;
    return v;
  endfunction : synth_clip

  function automatic logic [2:0] gain_clip(input logic [2:0] g);
    return (g > `DAC_GAIN_MAX) ? `DAC_GAIN_MAX : g;
  endfunction : gain_clip

  logic          run;
  logic          keep;
  logic          above;
  logic          trig_hit;
  logic [SW-1:0] lvl_sample;
  logic [4:0]    disc_top;

  assign run        = r_reg.state inside {dac_pkg::ST_CAPTURE, dac_pkg::ST_STREAM, dac_pkg::ST_PSTREAM};
  assign disc_top   = 5'((6'h01 << r_reg.discard) - 6'h01);
  // Discard first, so the level comparison sees only surviving samples
  assign keep       = sample_valid_i && (r_reg.disc_cnt == disc_top);
  assign lvl_sample = r_reg.lvl_ch2 ? sample_ch2_i : sample_ch1_i;
  assign above      = lvl_sample >= r_reg.thresh;

  always_comb begin
    trig_hit = 1'b0;
    if (r_reg.trig_en && (r_reg.trig_fall ? (r_reg.prev_trig && !ext_trig_i)
                                          : (!r_reg.prev_trig && ext_trig_i)))
      trig_hit = 1'b1;
    if (r_reg.lvl_en && keep && (r_reg.lvl_fall ? (r_reg.prev_above && !above)
                                                : (!r_reg.prev_above && above)))
      trig_hit = 1'b1;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    r_next            = r_reg;
    r_next.prev_trig  = ext_trig_i;
    r_next.gpio_in    = gpio_i;
    r_next.prev_gpio  = r_reg.gpio_in;
    r_next.clk2       = ~r_reg.clk2;
    r_next.trig_pulse = run && trig_hit;
    r_next.rdata      = 32'h0;

    // Timestamp request from digital input pulse when connector is an input
    r_next.stamp = r_reg.gpio_in && !r_reg.prev_gpio
                   && r_reg.gpio_sel == dac_pkg::GPIO_LOW && r_reg.mask[`DAC_ST_STAMP];

    if (r_reg.wvalid && ram_wready_i) r_next.wvalid = 1'b0;
    if (r_reg.hvalid && host_ready_i) r_next.hvalid = 1'b0;

    // Sample path
    if (sample_valid_i)
      r_next.disc_cnt = keep ? 5'h00 : r_reg.disc_cnt + 5'h01;
    if (keep) r_next.prev_above = above;
    if (run && trig_hit) r_next.armed = 1'b1;
    if (run && r_reg.armed && keep && !r_reg.wvalid) begin
      if (r_reg.chan == 2'h0) begin
        r_next.wdata  = {2'b00, sample_ch2_i, 2'b00, sample_ch1_i};
        r_next.wvalid = 1'b1;
      end else begin
        r_next.half = ~r_reg.half;
        r_next.hold = {2'b00, (r_reg.chan == 2'h2) ? sample_ch2_i : sample_ch1_i};
        if (r_reg.half) begin
          r_next.wdata  = {2'b00, (r_reg.chan == 2'h2) ? sample_ch2_i : sample_ch1_i, r_reg.hold};
          r_next.wvalid = 1'b1;
        end
      end
    end
    if (r_reg.wvalid && ram_wready_i && r_reg.state == dac_pkg::ST_CAPTURE) begin
      r_next.count = r_reg.count + 32'h4;
      if (r_reg.count + 32'h4 >= r_reg.memsize) begin
        r_next.state    = dac_pkg::ST_STANDBY;
        r_next.captured = 1'b1;
        r_next.armed    = 1'b0;
        r_next.status[`DAC_ST_FULL] = 1'b1;
      end
    end

    // Host delivery, paced to seven words in eight cycles
    r_next.credit = (r_reg.credit == `DAC_HOST_DEN - 4'h1) ? 4'h0 : r_reg.credit + 4'h1;
    if (ram_rready_o && ram_rvalid_i) begin
      r_next.hdata  = ram_rdata_i;
      r_next.hvalid = 1'b1;
      if (r_reg.state == dac_pkg::ST_XFER) begin
        r_next.count = r_reg.count + 32'h4;
        if (r_reg.count + 32'h4 >= r_reg.memsize) begin
          r_next.state    = dac_pkg::ST_STANDBY;
          r_next.captured = 1'b0;
          r_next.status[`DAC_ST_XFER] = 1'b1;
        end
      end
    end
    if (r_reg.state == dac_pkg::ST_PSTREAM && proc_ovalid_i && !r_reg.hvalid) begin
      r_next.hdata  = proc_odata_i;
      r_next.hvalid = 1'b1;
    end
    if (run && trig_hit) r_next.status[`DAC_ST_TRIG] = 1'b1;
    if (r_reg.stamp) r_next.status[`DAC_ST_STAMP] = 1'b1;

    // Register writes; status clear is write-one, set wins only for bits not already set
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `DAC_REG_MODE: begin
          r_next.count = 32'h0;
          r_next.armed = 1'b0;
          r_next.half  = 1'b0;
          unique case (reg_wdata_i[2:0])
            3'h1:    r_next.state = dac_pkg::ST_CAPTURE;
            3'h2:    r_next.state = r_reg.captured ? dac_pkg::ST_XFER : dac_pkg::ST_STANDBY;
            3'h3:    r_next.state = dac_pkg::ST_STREAM;
            3'h4:    r_next.state = dac_pkg::ST_PSTREAM;
            default: r_next.state = dac_pkg::ST_STANDBY;
          endcase
          if (reg_wdata_i[2:0] == 3'h1) r_next.captured = 1'b0;
        end
        `DAC_REG_CLOCK: begin
          r_next.ext_clk = reg_wdata_i[0];
          r_next.ext_ref = reg_wdata_i[1] && !reg_wdata_i[0];
          r_next.ext_div = (reg_wdata_i[8:4] < `DAC_EXT_DIV_MIN) ? `DAC_EXT_DIV_MIN :
                           (reg_wdata_i[8:4] > `DAC_EXT_DIV_MAX) ? `DAC_EXT_DIV_MAX : reg_wdata_i[8:4];
          r_next.discard = (reg_wdata_i[14:12] > `DAC_DISCARD_MAX) ? `DAC_DISCARD_MAX
                                                                 : reg_wdata_i[14:12];
          r_next.gpio_sel = reg_wdata_i[17:16];
        end
        `DAC_REG_SYNTH:   r_next.synth = synth_clip(reg_wdata_i[8:0]);
        `DAC_REG_CHAN: begin
          r_next.chan  = (reg_wdata_i[1:0] == 2'h3) ? 2'h0 : reg_wdata_i[1:0];
          r_next.gain1 = gain_clip(reg_wdata_i[6:4]);
          r_next.gain2 = gain_clip(reg_wdata_i[10:8]);
        end
        `DAC_REG_OFFSET1: r_next.off1 = reg_wdata_i[11:0];
        `DAC_REG_OFFSET2: r_next.off2 = reg_wdata_i[11:0];
        `DAC_REG_TRIGGER: begin
          r_next.trig_en   = reg_wdata_i[0];
          r_next.trig_fall = reg_wdata_i[1];
          r_next.lvl_en    = reg_wdata_i[2];
          r_next.lvl_fall  = reg_wdata_i[3];
          r_next.lvl_ch2   = reg_wdata_i[4];
          r_next.thresh    = reg_wdata_i[16+SW-1:16];
        end
        `DAC_REG_MEMSIZE:
          r_next.memsize = (reg_wdata_i[31:3] == 29'h0) ? `DAC_MEM_RST : {reg_wdata_i[31:3], 3'b000};
        `DAC_REG_STATUS:  r_next.status = (r_reg.status & ~reg_wdata_i[3:0]) | (r_next.status & ~r_reg.status);
        `DAC_REG_MASK:    r_next.mask = reg_wdata_i[3:0];
        default: ;
      endcase
    end

    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `DAC_REG_MODE:    r_next.rdata = {27'h0, r_reg.state};
        `DAC_REG_CLOCK:   r_next.rdata = {14'h0, r_reg.gpio_sel, 1'b0, r_reg.discard, 3'h0, r_reg.ext_div,
                                          2'h0, r_reg.ext_ref, r_reg.ext_clk};
        `DAC_REG_SYNTH:   r_next.rdata = {23'h0, r_reg.synth};
        `DAC_REG_CHAN:    r_next.rdata = {21'h0, r_reg.gain2, 1'b0, r_reg.gain1, 2'h0, r_reg.chan};
        `DAC_REG_OFFSET1: r_next.rdata = {20'h0, r_reg.off1};
        `DAC_REG_OFFSET2: r_next.rdata = {20'h0, r_reg.off2};
        `DAC_REG_TRIGGER: r_next.rdata = {2'h0, r_reg.thresh, 11'h0, r_reg.lvl_ch2, r_reg.lvl_fall,
                                          r_reg.lvl_en, r_reg.trig_fall, r_reg.trig_en};
        `DAC_REG_MEMSIZE: r_next.rdata = r_reg.memsize;
        `DAC_REG_STATUS:  r_next.rdata = {28'h0, r_reg.status};
        `DAC_REG_MASK:    r_next.rdata = {28'h0, r_reg.mask};
        `DAC_REG_COUNT:   r_next.rdata = r_reg.count;
        default:          r_next.rdata = 32'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      r_reg         <= '0;
      r_reg.state   <= dac_pkg::ST_STANDBY;
      r_reg.ext_div <= `DAC_EXT_DIV_MIN;
      r_reg.synth   <= `DAC_SYNTH_RST_MHZ;
      r_reg.memsize <= `DAC_MEM_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_comb begin
    unique case (r_reg.gpio_sel)
      dac_pkg::GPIO_LOW:  gpio_o = 1'b0;
      dac_pkg::GPIO_HIGH: gpio_o = 1'b1;
      dac_pkg::GPIO_TRIG: gpio_o = r_reg.trig_pulse;
      dac_pkg::GPIO_CLK2: gpio_o = r_reg.clk2;
    endcase
  end
  // Low selection doubles as the timestamp input, so the pin is released then
  assign gpio_oe_o     = r_reg.gpio_sel != dac_pkg::GPIO_LOW;
  assign stamp_req_o   = r_reg.stamp;
  assign reg_rdata_o   = r_reg.rdata;
  assign irq_o         = |(r_reg.status & r_reg.mask);
  assign ext_clk_sel_o = r_reg.ext_clk;
  assign ext_ref_sel_o = r_reg.ext_ref;
  assign ext_div_o     = r_reg.ext_div;
  assign synth_mhz_o   = r_reg.synth;
  assign offset1_o     = r_reg.off1;
  assign offset2_o     = r_reg.off2;
  assign gain1_o       = r_reg.gain1;
  assign gain2_o       = r_reg.gain2;
  assign ram_wdata_o   = r_reg.wdata;
  assign ram_wvalid_o  = r_reg.wvalid && r_reg.state != dac_pkg::ST_PSTREAM;
  assign proc_data_o   = r_reg.wdata;
  assign proc_valid_o  = r_reg.wvalid && r_reg.state == dac_pkg::ST_PSTREAM;
  // Reads interleave with writes: no read while a write word is pending
  assign ram_rready_o  = (r_reg.state == dac_pkg::ST_XFER || r_reg.state == dac_pkg::ST_STREAM)
                         && !r_reg.hvalid && !r_reg.wvalid && r_reg.credit != `DAC_HOST_DEN - 4'h1;
  assign host_data_o   = r_reg.hdata;
  assign host_valid_o  = r_reg.hvalid;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  synth_band_a: assert property (@(posedge clock_i) disable iff (reset_i)
    !(synth_mhz_o >= `DAC_BAND_LO_MHZ && synth_mhz_o <= `DAC_BAND_HI_MHZ)
    && synth_mhz_o >= `DAC_SYNTH_MIN_MHZ && synth_mhz_o <= `DAC_SYNTH_MAX_MHZ)
    else $error("synthesizer setting out of range");
  ext_div_a: assert property (@(posedge clock_i) disable iff (reset_i)
    ext_div_o >= `DAC_EXT_DIV_MIN && ext_div_o <= `DAC_EXT_DIV_MAX)
    else $error("external divider out of range");
  ref_sel_a: assert property (@(posedge clock_i) disable iff (reset_i)
    ext_clk_sel_o |-> !ext_ref_sel_o)
    else $error("connector used twice");
  xfer_gate_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (reg_wr_i && reg_addr_i == `DAC_REG_MODE && reg_wdata_i[2:0] == 3'h2 && !r_reg.captured)
    |=> r_reg.state == dac_pkg::ST_STANDBY)
    else $error("transfer without capture");
  host_pace_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (ram_rready_o && ram_rvalid_i) [*7] |=> !(ram_rready_o && ram_rvalid_i))
    else $error("host pacing broken");
  gain_range_a: assert property (@(posedge clock_i) disable iff (reset_i)
    gain1_o <= `DAC_GAIN_MAX && gain2_o <= `DAC_GAIN_MAX)
    else $error("gain out of range");
  mem_step_a: assert property (@(posedge clock_i) disable iff (reset_i)
    r_reg.memsize[2:0] == 3'b000 && r_reg.memsize != 32'h0)
    else $error("memory size not a multiple of eight");
  full_flag_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (r_reg.state == dac_pkg::ST_CAPTURE && ram_wvalid_o && ram_wready_i
     && r_reg.count + 32'h4 >= r_reg.memsize && !reg_wr_i)
    |=> r_reg.status[`DAC_ST_FULL] && r_reg.state == dac_pkg::ST_STANDBY)
    else $error("full not flagged");
  proc_route_a: assert property (@(posedge clock_i) disable iff (reset_i)
    r_reg.state == dac_pkg::ST_PSTREAM |-> !ram_wvalid_o && !ram_rready_o)
    else $error("processed data bypassed");
  fall_trig_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (run && r_reg.trig_en && r_reg.trig_fall && r_reg.prev_trig && !ext_trig_i && !reg_wr_i)
    |=> r_reg.armed)
    else $error("falling trigger missed");

endmodule : dac_acq_ctrl
`default_nettype wire

// [verification/dac_far_model.sv]
/*
  Far-side model: sample RAM used as a word queue, and the host bus sink.
  Assumes one clock shared with the design; stalls are random on both sides.
*/
`default_nettype none
module dac_far_model (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  // RAM write side
  input  wire logic [31:0] wdata_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  // RAM read side and host
  output logic             rvalid_o,
  output logic      [31:0] rdata_o,
  input  wire logic        rready_i,
  output logic             host_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic   [31:0] mem_q [$];
  logic   [31:0] last_word = 32'h0;
  integer        seed      = 32'h0badf00d;
  initial {wready_o, host_ready_o, rvalid_o, rdata_o} = '0;
  // Idle read data is the inverse of the last word, never a stale copy
  always @(posedge clock_i) begin
    wready_o     <= reset_i ? 1'b0 : 1'($random(seed));
    host_ready_o <= reset_i ? 1'b0 : 1'($random(seed));
    if (reset_i) begin
      mem_q.delete();
    end else begin
      if (rvalid_o && rready_i) begin
        last_word = mem_q.pop_front();
      end
      if (wvalid_i && wready_o) begin
        mem_q.push_back(wdata_i);
      end
    end
    rvalid_o <= mem_q.size() != 0;
    rdata_o  <= mem_q.size() != 0 ? mem_q[0] : ~last_word;
  end
endmodule : dac_far_model
`default_nettype wire

// [verification/tb_digitizer_acquisition_control.sv]
/*
  Self-checking bench for dac_acq_ctrl.
  Assumes dac_far_model stands in for the RAM and host sides.
*/
`default_nettype none
`include "dac_defs.svh"
module tb_digitizer_acquisition_control;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        clock_i = 1'b0, reset_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0, proc_odata_i = 32'h0, reg_rdata_o, ram_wdata_o, ram_rdata_i;
  logic [31:0] host_data_o, proc_data_o, d, w;
  logic        sample_valid_i = 1'b0, ext_trig_i = 1'b0, gpio_i = 1'b0, proc_ovalid_i = 1'b0;
  logic        irq_o, gpio_o, gpio_oe_o, stamp_req_o, ext_clk_sel_o, ext_ref_sel_o, proc_valid_o;
  logic        ram_wvalid_o, ram_wready_i, ram_rvalid_i, ram_rready_o, host_valid_o, host_ready_i;
  logic [13:0] sample_ch1_i = 14'h0, sample_ch2_i = 14'h0;
  logic [11:0] offset1_o, offset2_o;
  logic [8:0]  synth_mhz_o;
  logic [8:0]  sc [7] = '{9'h013, 9'h114, 9'h115, 9'h134, 9'h135, 9'h190, 9'h191};
  logic [4:0]  ext_div_o;
  logic [2:0]  gain1_o, gain2_o;
  logic [31:0] hq [$], eq [$];
  integer      fail_count = 0, checks = 0, stamps = 0, trigs = 0, seed = 32'h5d94ff84;

  dac_acq_ctrl uut (.clock_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .irq_o, .sample_valid_i, .sample_ch1_i, .sample_ch2_i, .ext_trig_i, .gpio_i, .gpio_o, .gpio_oe_o,
    .stamp_req_o, .ext_clk_sel_o, .ext_ref_sel_o, .ext_div_o, .synth_mhz_o, .offset1_o, .offset2_o,
    .gain1_o, .gain2_o, .ram_wdata_o, .ram_wvalid_o, .ram_wready_i, .ram_rvalid_i, .ram_rready_o,
    .ram_rdata_i, .host_data_o, .host_valid_o, .host_ready_i, .proc_data_o, .proc_valid_o,
    .proc_ovalid_i, .proc_odata_i);
  dac_far_model far (.clock_i, .reset_i, .wdata_i(ram_wdata_o), .wvalid_i(ram_wvalid_o),
    .wready_o(ram_wready_i), .rvalid_o(ram_rvalid_i), .rdata_o(ram_rdata_i), .rready_i(ram_rready_o),
    .host_ready_o(host_ready_i));

  always #50 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    if (host_valid_o && host_ready_i) hq.push_back(host_data_o);
    if (stamp_req_o === 1'b1) stamps++;
    if (gpio_oe_o && gpio_o === 1'b1) trigs++;
  end
  // ---------------------------------------------------------------
  // Tasks and expectations
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock_i);
    reg_addr_i <= a; reg_wdata_i <= v; reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    @(negedge clock_i);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clock_i);
    reg_addr_i <= a; reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    @(negedge clock_i);
    v = reg_rdata_o;
  endtask : rd
  task automatic stop_test;
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  function automatic logic [8:0] synth_exp(input logic [8:0] v);
    if (v < 9'h014) return 9'h014;
    if (v > 9'h190) return 9'h190;
    if (v >= 9'h115 && v <= 9'h134) return 9'h114;
    return v;
  endfunction : synth_exp
  function automatic logic [31:0] pack(input int cm, input logic [13:0] a, input logic [13:0] b);
    return {2'b00, cm == 1 ? a : b, 2'b00, cm == 2 ? b : a};
  endfunction : pack
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clock_i);
    reset_i <= 1'b0;
    @(negedge clock_i);
    check(ext_div_o, 5'h01);
    check(synth_mhz_o, 9'h190);
    wr(`DAC_REG_MODE, 32'h2);
    rd(`DAC_REG_MODE, d);
    check(d, dac_pkg::ST_STANDBY);
    rd(4'hf, d);
    check(d, 32'h0);
    for (int v = 0; v < 32; v++) begin
      wr(`DAC_REG_CLOCK, v << 4);
      check(ext_div_o, v < 1 ? 1 : v > 20 ? 20 : v);
    end
    wr(`DAC_REG_CLOCK, 32'h12);
    check({ext_clk_sel_o, ext_ref_sel_o}, 2'b01);
    wr(`DAC_REG_CLOCK, 32'h13);
    check({ext_clk_sel_o, ext_ref_sel_o}, 2'b10);
    for (int i = 0; i < 24; i++) begin
      w = i < 7 ? sc[i] : $random(seed) & 32'h1ff;
      wr(`DAC_REG_SYNTH, w);
      check(synth_mhz_o, synth_exp(w[8:0]));
    end
    for (int g = 0; g < 8; g++) begin
      w = $random(seed);
      wr(`DAC_REG_OFFSET1, w);
      wr(`DAC_REG_OFFSET2, ~w);
      check(offset1_o, w[11:0]);
      check(offset2_o, 12'(~w));
      wr(`DAC_REG_CHAN, (g << 4) | ((7 - g) << 8));
      check(gain1_o, g > 5 ? 5 : g);
      check(gain2_o, g < 2 ? 5 : 7 - g);
    end
    for (int s = 0; s < 4; s++) begin
      wr(`DAC_REG_CLOCK, s << 16);
      check(gpio_oe_o, s != 0);
      if (s < 2) check(gpio_o, s);
      if (s == 3) begin
        d[0] = gpio_o;
        @(negedge clock_i);
        check(gpio_o, !d[0]);
      end
    end
    wr(`DAC_REG_MEMSIZE, 32'h13);
    wr(`DAC_REG_CLOCK, 32'h20000);
    trigs = 0;
    for (int cm = 0; cm < 4; cm++) begin
      w = $random(seed) | 1;
      @(posedge clock_i);
      ext_trig_i <= cm == 1;
      sample_ch1_i <= cm == 3 ? 14'h0 : w[13:0]; sample_ch2_i <= w[29:16]; sample_valid_i <= 1'b1;
      wr(`DAC_REG_MODE, 32'h0);
      wr(`DAC_REG_STATUS, 32'hf);
      wr(`DAC_REG_TRIGGER, cm == 3 ? {2'b00, w[13:0], 16'h4} : cm == 1 ? 32'h3 : 32'h1);
      wr(`DAC_REG_CHAN, cm);
      wr(`DAC_REG_MODE, 32'h1);
      repeat (20) @(posedge clock_i);
      check(far.mem_q.size(), 0);
      ext_trig_i <= cm != 1;
      sample_ch1_i <= w[13:0];
      d = 0;
      for (int i = 0; i < 300 && d[0] !== 1'b1; i++) rd(`DAC_REG_STATUS, d);
      check(d[0], 1'b1);
      check(far.mem_q.size(), 4);
      foreach (far.mem_q[i]) check(far.mem_q[i], pack(cm, w[13:0], w[29:16]));
      rd(`DAC_REG_MODE, d);
      check(d, dac_pkg::ST_STANDBY);
      rd(`DAC_REG_COUNT, d);
      check(d, 32'h10);
      eq = far.mem_q;
      hq.delete();
      wr(`DAC_REG_MODE, 32'h2);
      for (int i = 0; i < 300 && hq.size() < 4; i++) @(posedge clock_i);
      check(hq.size(), 4);
      foreach (eq[i]) check(hq[i], eq[i]);
    end
    check(trigs, 4);
    @(posedge clock_i);
    ext_trig_i <= 1'b0;
    wr(`DAC_REG_TRIGGER, 32'h1);
    wr(`DAC_REG_MODE, 32'h3);
    hq.delete();
    @(posedge clock_i);
    ext_trig_i <= 1'b1;
    repeat (200) @(posedge clock_i);
    wr(`DAC_REG_MODE, 32'h0);
    check(hq.size() > 4, 1'b1);
    foreach (hq[i]) check(hq[i], pack(0, w[13:0], w[29:16]));
    check(irq_o, 1'b0);
    wr(`DAC_REG_MASK, 32'h1);
    rd(`DAC_REG_STATUS, d);
    check(irq_o, 1'b1);
    wr(`DAC_REG_STATUS, 32'hf);
    rd(`DAC_REG_STATUS, d);
    check(d[0], 1'b0);
    check(irq_o, 1'b0);
    wr(`DAC_REG_CLOCK, 32'h0);
    wr(`DAC_REG_MASK, 32'h4);
    @(posedge clock_i);
    gpio_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    rd(`DAC_REG_STATUS, d);
    check(d[2], 1'b1);
    check(stamps, 1);
    check(irq_o, 1'b1);
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    stop_test();
  end
endmodule : tb_digitizer_acquisition_control
`default_nettype wire
